/* src/pmac_ctrl.v */
// Power-mode, clock-gate and auto-sleep control with its host register file.
`timescale 1ns/1ps
`default_nettype none
`include "pmac_defines.vh"

module pmac_ctrl #(
	parameter integer TICK_CYCLES = `PMAC_TICK_US * `PMAC_CLK_MHZ
) (
	input  wire       mclk,             // System clock, 100 MHz.
	input  wire       sys_rst,          // Power-on or reset pin, async, active high.
	input  wire       soft_reset_done,  // Pulse as a software reset completes.
	input  wire [7:0] reg_addr,         // Register address from the serial slave.
	input  wire [7:0] reg_wdata,        // Register write data.
	input  wire       reg_wr,           // Register write strobe, one cycle.
	input  wire       reg_rd,           // Register read strobe, one cycle.
	input  wire       key_event,        // Keypad activity pulse.
	input  wire       wake_event,       // Wake-up request while asleep.
	input  wire [6:0] irq_sources,      // Status bits of the other blocks.
	output reg  [7:0] reg_rdata,        // Read data, valid the cycle after reg_rd.
	output reg  [1:0] mode_select_field,    // Current operating mode.
	output reg        keyscan_clock_gate,   // Keypad scan clock enable.
	output reg        pwm_timer_clock_gate, // Shared PWM timer clock enable.
	output reg        pwm_force_off,        // Pulse that turns active PWM outputs off.
	output reg        supply_fail_flag,     // Supply-failure interrupt flag.
	output reg        asleep                // High while in sleep mode.
);

	// ********************************************************************
	// Register state
	// ********************************************************************
	reg        autosleep_enable_bit;
	reg [7:0]  timeout_low;
	reg [2:0]  timeout_high;
	wire [10:0] idle_timeout_value;
	wire        timer_expire;
	wire        timer_run;
	wire        activity;
	wire        host_access;
	reg  [1:0]  next_mode;
	reg         next_flag;
	reg  [7:0]  next_rdata;
	wire        wr_mode;
	wire        wr_flag_clear;
	wire        wr_clock_gate;
	wire        wr_autosleep;
	wire        wr_timeout_low;
	wire        wr_timeout_high;
	wire        flag_set;
	wire        flag_clear;
	wire        timeout_zero;
	wire        in_normal;
	wire [6:0]  live_sources;

	// State codes of the mode machine are the mode field codes themselves.
	localparam [1:0] ST_SLEEP  = `PMAC_MODE_SLEEP;
	localparam [1:0] ST_NORMAL = `PMAC_MODE_NORMAL;
	// Status positions that carry a live source; the others are reserved.
	localparam [6:0] LIVE_MASK = `PMAC_IRQ_LIVE_MASK;

	// Decoded write strobe for one register address.
	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		input       strobe;
		begin
			wr_hit = strobe && (addr == target);
		end
	endfunction

	assign idle_timeout_value = {timeout_high, timeout_low};
	// Reads count as activity too, so a host that polls keeps the device awake.
	assign host_access        = reg_wr || reg_rd;
	assign activity           = host_access || key_event;

	// ********************************************************************
	// Write strobe decode
	// ********************************************************************
	assign wr_mode         = wr_hit(reg_addr, `PMAC_ADDR_OPERATING_MODE, reg_wr);
	assign wr_flag_clear   = wr_hit(reg_addr, `PMAC_ADDR_RESET_FLAG_CLEAR, reg_wr);
	assign wr_clock_gate   = wr_hit(reg_addr, `PMAC_ADDR_UNIT_CLOCK_GATE, reg_wr);
	assign wr_autosleep    = wr_hit(reg_addr, `PMAC_ADDR_AUTOSLEEP_ENABLE, reg_wr);
	assign wr_timeout_low  = wr_hit(reg_addr, `PMAC_ADDR_IDLE_TIMEOUT_LOW, reg_wr);
	assign wr_timeout_high = wr_hit(reg_addr, `PMAC_ADDR_IDLE_TIMEOUT_HIGH, reg_wr);
	assign flag_set        = soft_reset_done;
	assign flag_clear      = wr_flag_clear && reg_wdata[`PMAC_FAIL_CLEAR_BIT];

	// ********************************************************************
	// Idle timer control
	// ********************************************************************
	assign timeout_zero = (idle_timeout_value == 11'h000);
	assign in_normal    = (mode_select_field == ST_NORMAL);

	// Counting only in normal mode with a non-zero timeout.
	assign timer_run = autosleep_enable_bit
	                && !timeout_zero
	                && in_normal;

	// ********************************************************************
	// Global status bits
	// ********************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1)
		begin : g_live
			// Reserved status positions read as zero whatever the source shows.
			assign live_sources[gi] = irq_sources[gi] & LIVE_MASK[gi];
		end
	endgenerate

	// ********************************************************************
	// Idle timer
	// ********************************************************************
	// The timer reloads itself on activity, so expiry needs unbroken idle time.
	pmac_idle_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.TW          (11)
	) u_idle (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.run     (timer_run),
		.restart (activity),
		.timeout (idle_timeout_value),
		.expire  (timer_expire)
	);

	// ********************************************************************
	// Mode next state
	// ********************************************************************
	always @*
	begin
		next_mode = mode_select_field;
		case (mode_select_field)
			ST_SLEEP:
			begin
				// A mode write outranks a wake request in the same cycle.
				if (wr_mode && (reg_wdata[1:0] == ST_NORMAL))
					next_mode = ST_NORMAL;
				else if (!wr_mode && wake_event)
					next_mode = ST_NORMAL;
			end
			ST_NORMAL:
			begin
				// Reserved codes with the upper bit set leave the mode alone.
				if (wr_mode && (reg_wdata[1:0] == ST_SLEEP))
					next_mode = ST_SLEEP;
				else if (!wr_mode && timer_expire && timer_run)
					next_mode = ST_SLEEP;
			end
			default:
			begin
				// The reserved codes are never entered; recover to operation.
				next_mode = ST_NORMAL;
			end
		endcase
	end

	// ********************************************************************
	// Supply-failure flag next state
	// ********************************************************************
	always @*
	begin
		next_flag = supply_fail_flag;
		// A reset ending in the clearing cycle still leaves the flag set.
		if (flag_set)
			next_flag = 1'b1;
		else if (flag_clear)
			next_flag = 1'b0;
	end

	// ********************************************************************
	// Supply-failure flag register
	// ********************************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			supply_fail_flag <= `PMAC_RST_SUPPLY_FAIL;
		else
			supply_fail_flag <= next_flag;
	end

	// ********************************************************************
	// Mode, PWM-off pulse and sleep-state outputs
	// ********************************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_select_field <= `PMAC_RST_MODE;
			pwm_force_off     <= 1'b0;
			asleep            <= 1'b0;
		end
		else
		begin
			mode_select_field <= next_mode;
			// Turn PWM outputs off only on the step from operation into sleep.
			pwm_force_off     <= (mode_select_field == `PMAC_MODE_NORMAL)
			                  && (next_mode == `PMAC_MODE_SLEEP);
			// Sleep follows the next mode so it never lags the mode field.
			asleep            <= (next_mode == `PMAC_MODE_SLEEP);
		end
	end

	// ********************************************************************
	// Writable configuration registers
	// ********************************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			keyscan_clock_gate   <= `PMAC_RST_KEYSCAN_GATE;
			pwm_timer_clock_gate <= `PMAC_RST_PWM_GATE;
		end
		else if (wr_clock_gate)
		begin
			keyscan_clock_gate   <= reg_wdata[`PMAC_KEYSCAN_GATE_BIT];
			pwm_timer_clock_gate <= reg_wdata[`PMAC_PWM_GATE_BIT];
		end
	end

	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			autosleep_enable_bit <= `PMAC_RST_AUTOSLEEP;
		else if (wr_autosleep)
			autosleep_enable_bit <= reg_wdata[`PMAC_AUTOSLEEP_BIT];
	end

	// ********************************************************************
	// Idle timeout registers
	// ********************************************************************
	// The halves load independently, so a host changing both writes twice.
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			timeout_low <= `PMAC_RST_TIMEOUT_LOW;
		else if (wr_timeout_low)
			timeout_low <= reg_wdata;
	end

	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			timeout_high <= `PMAC_RST_TIMEOUT_HIGH;
		else if (wr_timeout_high)
			timeout_high <= reg_wdata[`PMAC_TIMEOUT_HIGH_MSB:0];
	end

	// ********************************************************************
	// Read data
	// ********************************************************************
	always @*
	begin
		next_rdata = 8'h00;
		// Reserved bits and unmapped or write-only addresses read as zero.
		if (reg_addr == `PMAC_ADDR_OPERATING_MODE)
			next_rdata = {6'h00, mode_select_field};
		else if (reg_addr == `PMAC_ADDR_UNIT_CLOCK_GATE)
			next_rdata = {5'h00, pwm_timer_clock_gate, 1'b0, keyscan_clock_gate};
		else if (reg_addr == `PMAC_ADDR_AUTOSLEEP_ENABLE)
			next_rdata = {7'h00, autosleep_enable_bit};
		else if (reg_addr == `PMAC_ADDR_IDLE_TIMEOUT_LOW)
			next_rdata = timeout_low;
		else if (reg_addr == `PMAC_ADDR_IDLE_TIMEOUT_HIGH)
			next_rdata = {5'h00, timeout_high};
		else if (reg_addr == `PMAC_ADDR_GLOBAL_IRQ_STATUS)
			next_rdata = {supply_fail_flag, live_sources};
	end

	// ********************************************************************
	// Read data register
	// ********************************************************************
	// Read data holds between reads so a slow serial slave can shift it out.
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

endmodule

`default_nettype wire

/* src/pmac_defines.vh */
// Register map, field positions, reset values and timing constants of the power-mode block.
`ifndef PMAC_DEFINES_VH
`define PMAC_DEFINES_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define PMAC_ADDR_RESET_FLAG_CLEAR   8'h84
`define PMAC_ADDR_OPERATING_MODE     8'h88
`define PMAC_ADDR_UNIT_CLOCK_GATE    8'h8a
`define PMAC_ADDR_AUTOSLEEP_ENABLE   8'h8b
`define PMAC_ADDR_IDLE_TIMEOUT_LOW   8'h8c
`define PMAC_ADDR_IDLE_TIMEOUT_HIGH  8'h8d
`define PMAC_ADDR_GLOBAL_IRQ_STATUS  8'h91

// ********************************************************************
// Field positions
// ********************************************************************
`define PMAC_FAIL_CLEAR_BIT          0
`define PMAC_KEYSCAN_GATE_BIT        0
`define PMAC_PWM_GATE_BIT            2
`define PMAC_AUTOSLEEP_BIT           0
`define PMAC_SUPPLY_FAIL_BIT         7
`define PMAC_TIMEOUT_HIGH_MSB        2
`define PMAC_IRQ_LIVE_MASK           7'h4f

// ********************************************************************
// Mode encodings and reset values
// ********************************************************************
`define PMAC_MODE_SLEEP              2'h0
`define PMAC_MODE_NORMAL             2'h1
`define PMAC_RST_MODE                2'h1
`define PMAC_RST_KEYSCAN_GATE        1'h0
`define PMAC_RST_PWM_GATE            1'h0
`define PMAC_RST_AUTOSLEEP           1'h0
`define PMAC_RST_TIMEOUT_LOW         8'hff
`define PMAC_RST_TIMEOUT_HIGH        3'h0
`define PMAC_RST_SUPPLY_FAIL         1'h1

// ********************************************************************
// Timing
// ********************************************************************
`define PMAC_TICK_US                 4000
`define PMAC_CLK_MHZ                 100

`endif

/* src/pmac_idle_timer.v */
// Idle timer that counts whole 4 ms units down from the programmed timeout.
`timescale 1ns/1ps
`default_nettype none

module pmac_idle_timer #(
	parameter integer TICK_CYCLES = 400000,
	parameter integer TW          = 11
) (
	input  wire          mclk,     // System clock.
	input  wire          sys_rst,  // Asynchronous reset, active high.
	input  wire          run,      // Timer may count.
	input  wire          restart,  // Activity seen, reload the timeout.
	input  wire [TW-1:0] timeout,  // Idle time in 4 ms units.
	output reg           expire    // One-cycle pulse when the idle time elapses.
);

	localparam integer PW       = $clog2(TICK_CYCLES);
	localparam integer LAST_INT = TICK_CYCLES - 1;
	// Terminal prescaler count, cut to the prescaler width on purpose.
	localparam [PW-1:0] LAST    = LAST_INT[PW-1:0];

	reg [PW-1:0] prescale;
	reg [TW-1:0] units;

	// ********************************************************************
	// Prescaler and unit counter
	// ********************************************************************
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prescale <= {PW{1'b0}};
			units    <= {TW{1'b0}};
			expire   <= 1'b0;
		end
		else if (!run || restart)
		begin
			// Any activity restarts a full idle interval.
			prescale <= {PW{1'b0}};
			units    <= timeout;
			expire   <= 1'b0;
		end
		else if (prescale == LAST)
		begin
			prescale <= {PW{1'b0}};
			if (units == {{(TW-1){1'b0}}, 1'b1})
			begin
				units  <= timeout;
				expire <= 1'b1;
			end
			else
			begin
				units  <= units - {{(TW-1){1'b0}}, 1'b1};
				expire <= 1'b0;
			end
		end
		else
		begin
			prescale <= prescale + {{(PW-1){1'b0}}, 1'b1};
			expire   <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* dv/pmac_ctrl_chk.sv */
// Port-level assertions for the power-mode control block.
`timescale 1ns/1ps
`default_nettype none
module pmac_ctrl_chk (
	input wire logic       mclk,                 // Clock.
	input wire logic       sys_rst,              // Reset.
	input wire logic       soft_reset_done,      // Soft reset end.
	input wire logic [7:0] reg_addr,             // Address.
	input wire logic [7:0] reg_wdata,            // Write data.
	input wire logic       reg_wr,               // Write strobe.
	input wire logic       reg_rd,               // Read strobe.
	input wire logic [7:0] reg_rdata,            // Read data.
	input wire logic [1:0] mode_select_field,    // Mode.
	input wire logic       keyscan_clock_gate,   // Key gate.
	input wire logic       pwm_timer_clock_gate, // PWM gate.
	input wire logic       pwm_force_off,        // PWM off pulse.
	input wire logic       supply_fail_flag,     // Flag.
	input wire logic       asleep                // Sleep.
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_sleep_write: assert property (
		reg_wr && reg_addr == 8'h88 && reg_wdata[1:0] == 2'h0 |=> mode_select_field == 2'h0 && asleep)
		else $error("mode write of sleep not taken");
	a_mode_legal: assert property (!mode_select_field[1] && asleep == (mode_select_field == 2'h0))
		else $error("mode field illegal");
	a_force_off: assert property (pwm_force_off == $rose(asleep))
		else $error("pwm off pulse wrong");
	a_flag_set: assert property (soft_reset_done |=> supply_fail_flag)
		else $error("flag not set by soft reset");
	a_flag_clear: assert property (
		reg_wr && reg_addr == 8'h84 && reg_wdata[0] && !soft_reset_done |=> !supply_fail_flag)
		else $error("flag not cleared");
	a_flag_rise: assert property ($rose(supply_fail_flag) |-> $past(soft_reset_done))
		else $error("flag rose without reset");
	a_gate_write: assert property (reg_wr && reg_addr == 8'h8a |=>
		{pwm_timer_clock_gate, keyscan_clock_gate} == $past({reg_wdata[2], reg_wdata[0]}))
		else $error("clock gates not written");
	a_gate_hold: assert property (!(reg_wr && reg_addr == 8'h8a) |=>
		$stable({pwm_timer_clock_gate, keyscan_clock_gate}))
		else $error("clock gates changed");
	a_read_mode: assert property (reg_rd && reg_addr == 8'h88 |=>
		reg_rdata == {6'h00, $past(mode_select_field)})
		else $error("mode read wrong");
	a_read_wo: assert property (reg_rd && reg_addr == 8'h84 |=> reg_rdata == 8'h00)
		else $error("write-only register read nonzero");
endmodule
`default_nettype wire

/* dv/pmac_host_model.sv */
// Host model driving the register strobe port.
`timescale 1ns/1ps
`default_nettype none
module pmac_host_model (
	input  wire logic       mclk,      // Clock.
	input  wire logic [7:0] reg_rdata, // Read data.
	output var  logic [7:0] reg_addr,  // Address.
	output var  logic [7:0] reg_wdata, // Write data.
	output var  logic       reg_wr,    // Write strobe.
	output var  logic       reg_rd     // Read strobe.
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released lines show the inverse so stale values cannot pass by chance.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the power-mode and auto-sleep block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam integer TICK = 10;
	logic        mclk, sys_rst, soft_reset_done, key_event, wake_event;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
	logic        reg_wr, reg_rd, keyscan_clock_gate, pwm_timer_clock_gate, pwm_force_off;
	logic        supply_fail_flag, asleep;
	logic [1:0]  mode_select_field;
	logic [6:0]  irq_sources;
	logic [24:0] rows [0:17];
	int          miscompares, n_compared, cycles, i, n;
	pmac_ctrl #(.TICK_CYCLES(TICK)) dut_u (.mclk, .sys_rst, .soft_reset_done, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .key_event, .wake_event, .irq_sources, .reg_rdata,
		.mode_select_field, .keyscan_clock_gate, .pwm_timer_clock_gate, .pwm_force_off,
		.supply_fail_flag, .asleep);
	pmac_host_model host_u (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic pulse_key;
		@(negedge mclk);
		key_event = 1'b1;
		@(negedge mclk);
		key_event = 1'b0;
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			finish_test;
		end
	end
	initial
	begin
		{sys_rst, soft_reset_done, key_event, wake_event, irq_sources} = {4'h8, 7'h7f};
		// Row: write flag, address, write data, expected read back.
		rows = '{{1'b0, 24'h880001}, {1'b0, 24'h8a0000}, {1'b0, 24'h8b0000}, {1'b0, 24'h8c00ff},
			{1'b0, 24'h8d0000}, {1'b0, 24'h9100cf}, {1'b0, 24'h840000}, {1'b0, 24'h900000},
			{1'b1, 24'h8aff05}, {1'b1, 24'h8a0000}, {1'b1, 24'h8bff01}, {1'b1, 24'h8b0000},
			{1'b1, 24'h8c5a5a}, {1'b1, 24'h8dff07}, {1'b1, 24'h8d0000}, {1'b1, 24'h880201},
			{1'b1, 24'h880000}, {1'b1, 24'h880101}};
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
		for (i = 0; i < 18; i++)
		begin
			if (rows[i][24])
				host_u.write_reg(rows[i][23:16], rows[i][15:8]);
			host_u.read_reg(rows[i][23:16], rd);
			check("register", rows[i][7:0], rd);
		end
		$display("Register table test done");
		host_u.write_reg(8'h84, 8'h00);
		host_u.read_reg(8'h91, rd);
		check("status after clear of 0", 8'hcf, rd);
		host_u.write_reg(8'h84, 8'h01);
		host_u.read_reg(8'h91, rd);
		check("status after clear", 8'h4f, rd);
		@(negedge mclk);
		soft_reset_done = 1'b1;
		@(negedge mclk);
		soft_reset_done = 1'b0;
		host_u.read_reg(8'h91, rd);
		check("status after soft reset", 8'hcf, rd);
		fork
			host_u.write_reg(8'h84, 8'h01);
			begin
				@(negedge mclk);
				soft_reset_done = 1'b1;
				@(negedge mclk);
				soft_reset_done = 1'b0;
			end
		join
		host_u.read_reg(8'h91, rd);
		check("status after clear with soft reset", 8'hcf, rd);
		$display("Flag test done");
		host_u.write_reg(8'h8b, 8'h01);
		host_u.write_reg(8'h88, 8'h00);
		check("asleep after mode write", 8'h01, {7'h00, asleep});
		@(negedge mclk);
		wake_event = 1'b1;
		@(negedge mclk);
		wake_event = 1'b0;
		check("mode after wake", 8'h01, {6'h00, mode_select_field});
		host_u.write_reg(8'h8c, 8'h00);
		repeat (100) @(negedge mclk);
		check("asleep with zero timeout", 8'h00, {7'h00, asleep});
		host_u.write_reg(8'h8c, 8'h03);
		for (i = 0; i < 6; i++)
		begin
			repeat (3 * TICK - 8) @(negedge mclk);
			pulse_key();
		end
		check("asleep while active", 8'h00, {7'h00, asleep});
		n = 0;
		while (!asleep && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
		check("idle expiry in window", 8'h01, {7'h00, n >= 3 * TICK - 1 && n <= 3 * TICK + 3});
		$display("Auto-sleep test done");
		host_u.write_reg(8'h84, 8'h01);
		@(negedge mclk);
		sys_rst = 1'b1;
		repeat (3) @(negedge mclk);
		sys_rst = 1'b0;
		check("asleep after pin reset", 8'h00, {7'h00, asleep});
		host_u.read_reg(8'h91, rd);
		check("status after pin reset", 8'hcf, rd);
		host_u.read_reg(8'h8c, rd);
		check("timeout after pin reset", 8'hff, rd);
		$display("Pin reset test done");
		finish_test;
	end
endmodule
bind pmac_ctrl pmac_ctrl_chk chk_u (.mclk, .sys_rst, .soft_reset_done, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .mode_select_field, .keyscan_clock_gate,
	.pwm_timer_clock_gate, .pwm_force_off, .supply_fail_flag, .asleep);
`default_nettype wire
